// ---- logic/edge_latch.sv ----
// Rising-edge detector feeding a sticky flag that clears on read.
`timescale 1ns/1ns
module edge_latch (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic level,
  input  wire logic clear,
  output logic      flag
);

  typedef struct packed {
    logic prev;
    logic flag;
  } latch_s;

  latch_s stateReg;
  latch_s stateNext;

  // A rising edge in the clearing cycle sets the flag: set wins.
  always_comb begin
    stateNext      = stateReg;
    stateNext.prev = level;
    if (clear) begin
      stateNext.flag = 1'b0;
    end
    if (level && !stateReg.prev) begin
      stateNext.flag = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stateReg <= '0;
    end else begin
      stateReg <= stateNext;
    end
  end

  assign flag = stateReg.flag;

endmodule

// ---- logic/event_status_latches.sv ----
// Event status latches with clear-on-read, mask and interrupt output.
`timescale 1ns/1ns
// Functional notes
// - Status bits clear when host reads them.
// - Clock periodic, second, alarm set bits 7,6,5.
// - Battery thresholds set bits 2,1,0 on rise.
// - Sink regulation loss sets bits 13,12.
// - USB current limit sets bit 10.
// - Summary bit 5 flags comparators, clears on read.
module event_status_latches (
  input  wire logic                                 clk,
  input  wire logic                                 rst_n,
  input  wire logic [event_status_pkg::ADDR_W-1:0]  regAddr,
  input  wire logic [event_status_pkg::DATA_W-1:0]  regWdata,
  input  wire logic                                 regWrite,
  input  wire logic                                 regRead,
  output logic      [event_status_pkg::DATA_W-1:0]  regRdata,
  input  wire logic                                 clockPeriodicEvent,
  input  wire logic                                 clockSecondTickEvent,
  input  wire logic                                 clockAlarmEvent,
  input  wire logic                                 batteryBelowHighEvent,
  input  wire logic                                 batteryBelowMidEvent,
  input  wire logic                                 batteryBelowLowEvent,
  input  wire logic                                 sinkOneRegulationLost,
  input  wire logic                                 sinkTwoRegulationLost,
  input  wire logic                                 usbCurrentLimitEvent,
  input  wire logic                                 auxConversionReadyEvent,
  input  wire logic [event_status_pkg::AUX_COMP_N-1:0] auxComparatorEvent,
  output logic                                      irq
);
  import event_status_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [DATA_W-1:0] maskOne;
    logic [DATA_W-1:0] maskTwo;
    logic [DATA_W-1:0] rdata;
  } regs_s;

  regs_s regsReg;
  regs_s regsNext;

  logic [DATA_W-1:0] srcOne;
  logic [DATA_W-1:0] srcTwo;
  logic [DATA_W-1:0] srcSum;
  logic [DATA_W-1:0] statOne;
  logic [DATA_W-1:0] statTwo;
  logic [DATA_W-1:0] statSum;
  logic              rdOne;
  logic              rdTwo;
  logic              rdSum;

  // ---------------------------------------------------------------
  // Event sources
  // ---------------------------------------------------------------
  always_comb begin
    srcOne                   = '0;
    srcOne[CLK_PERIODIC_BIT] = clockPeriodicEvent;
    srcOne[CLK_SECOND_BIT]   = clockSecondTickEvent;
    srcOne[CLK_ALARM_BIT]    = clockAlarmEvent;
    srcOne[BATT_HIGH_BIT]    = batteryBelowHighEvent;
    srcOne[BATT_MID_BIT]     = batteryBelowMidEvent;
    srcOne[BATT_LOW_BIT]     = batteryBelowLowEvent;
    srcTwo                   = '0;
    srcTwo[SINK_ONE_BIT]     = sinkOneRegulationLost;
    srcTwo[SINK_TWO_BIT]     = sinkTwoRegulationLost;
    srcTwo[USB_LIMIT_BIT]    = usbCurrentLimitEvent;
    srcTwo[AUX_READY_BIT]    = auxConversionReadyEvent;
    srcTwo[AUX_COMP_LSB +: AUX_COMP_N] = auxComparatorEvent;
    srcSum                   = '0;
    srcSum[AUX_GROUP_BIT]    = |auxComparatorEvent;
  end

  assign rdOne = regRead && (regAddr == STATUS_ONE_OFS);
  assign rdTwo = regRead && (regAddr == STATUS_TWO_OFS);
  assign rdSum = regRead && (regAddr == SUMMARY_OFS);

  // ---------------------------------------------------------------
  // Latches, one per implemented bit
  // ---------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < DATA_W; i++) begin : g_bit
      if (i == CLK_PERIODIC_BIT || i == CLK_SECOND_BIT ||
          i == CLK_ALARM_BIT || i <= BATT_HIGH_BIT) begin : g_one
        edge_latch u_one (
          .clk   (clk),
          .rst_n (rst_n),
          .level (srcOne[i]),
          .clear (rdOne),
          .flag  (statOne[i])
        );
      end else begin : g_one_z
        assign statOne[i] = 1'b0;
      end
      if (i == SINK_ONE_BIT || i == SINK_TWO_BIT ||
          i == USB_LIMIT_BIT ||
          (i >= AUX_COMP_LSB && i <= AUX_READY_BIT)) begin : g_two
        edge_latch u_two (
          .clk   (clk),
          .rst_n (rst_n),
          .level (srcTwo[i]),
          .clear (rdTwo),
          .flag  (statTwo[i])
        );
      end else begin : g_two_z
        assign statTwo[i] = 1'b0;
      end
    end
  endgenerate

  // Summary flag sets when the comparator inputs leave the all-low state.
  edge_latch u_sum (
    .clk   (clk),
    .rst_n (rst_n),
    .level (srcSum[AUX_GROUP_BIT]),
    .clear (rdSum),
    .flag  (statSum[AUX_GROUP_BIT])
  );
  assign statSum[DATA_W-1:AUX_GROUP_BIT+1] = '0;
  assign statSum[AUX_GROUP_BIT-1:0]        = '0;

  // ---------------------------------------------------------------
  // Register port
  // ---------------------------------------------------------------
  always_comb begin
    regsNext       = regsReg;
    regsNext.rdata = '0;
    if (regWrite && regAddr == MASK_ONE_OFS) begin
      regsNext.maskOne = regWdata;
    end
    if (regWrite && regAddr == MASK_TWO_OFS) begin
      regsNext.maskTwo = regWdata;
    end
    if (regRead) begin
      case (regAddr)
        SUMMARY_OFS:    regsNext.rdata = statSum;
        STATUS_ONE_OFS: regsNext.rdata = statOne;
        STATUS_TWO_OFS: regsNext.rdata = statTwo;
        MASK_ONE_OFS:   regsNext.rdata = regsReg.maskOne;
        MASK_TWO_OFS:   regsNext.rdata = regsReg.maskTwo;
        default:        regsNext.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      regsReg <= {MASK_RST, MASK_RST, STATUS_RST};
    end else begin
      regsReg <= regsNext;
    end
  end

  assign regRdata = regsReg.rdata;
  // Mask bit one enables the matching status bit onto the output.
  assign irq = |(statOne & regsReg.maskOne) |
               |(statTwo & regsReg.maskTwo);

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  // The latch history restarts at reset, so the cycle after it is skipped.
  sequence s_read_one_quiet;
    rdOne && $past(rst_n) &&
    !(clockAlarmEvent && !$past(clockAlarmEvent))
    ##1 !clockAlarmEvent;
  endsequence

  property p_read_clears_one;
    @(posedge clk) disable iff (!rst_n)
      s_read_one_quiet |-> !statOne[CLK_ALARM_BIT];
  endproperty
  a_read_clears_one: assert property (p_read_clears_one)
    else $error("alarm flag not cleared by read");

  property p_alarm_sets;
    @(posedge clk) disable iff (!rst_n)
      $rose(clockAlarmEvent) |=> statOne[CLK_ALARM_BIT];
  endproperty
  a_alarm_sets: assert property (p_alarm_sets)
    else $error("alarm edge not latched");

  property p_batt_sets;
    @(posedge clk) disable iff (!rst_n)
      $rose(batteryBelowLowEvent) |=> statOne[BATT_LOW_BIT];
  endproperty
  a_batt_sets: assert property (p_batt_sets)
    else $error("battery low edge not latched");

  property p_sink_sets;
    @(posedge clk) disable iff (!rst_n)
      $rose(sinkOneRegulationLost) |=> statTwo[SINK_ONE_BIT];
  endproperty
  a_sink_sets: assert property (p_sink_sets)
    else $error("sink one edge not latched");

  property p_usb_sets;
    @(posedge clk) disable iff (!rst_n)
      $rose(usbCurrentLimitEvent) |=> statTwo[USB_LIMIT_BIT];
  endproperty
  a_usb_sets: assert property (p_usb_sets)
    else $error("usb limit edge not latched");

  property p_comp_sets;
    @(posedge clk) disable iff (!rst_n)
      $rose(auxComparatorEvent[0]) |=> statTwo[AUX_COMP_LSB];
  endproperty
  a_comp_sets: assert property (p_comp_sets)
    else $error("comparator one edge not latched");

  property p_sum_sets;
    @(posedge clk) disable iff (!rst_n)
      $rose(|auxComparatorEvent) |=> statSum[AUX_GROUP_BIT];
  endproperty
  a_sum_sets: assert property (p_sum_sets)
    else $error("summary comparator flag not set");

  property p_read_data;
    @(posedge clk) disable iff (!rst_n)
      rdTwo |=> regRdata == $past(statTwo);
  endproperty
  a_read_data: assert property (p_read_data)
    else $error("status two read data wrong");

  sequence s_usb_held_read;
    rdTwo && $past(rst_n) &&
    usbCurrentLimitEvent && $past(usbCurrentLimitEvent)
    ##1 usbCurrentLimitEvent;
  endsequence

  property p_level_no_retrigger;
    @(posedge clk) disable iff (!rst_n)
      s_usb_held_read |-> !statTwo[USB_LIMIT_BIT];
  endproperty
  a_level_no_retrigger: assert property (p_level_no_retrigger)
    else $error("held level retriggered usb flag");

endmodule

// ---- logic/event_status_pkg.sv ----
// Package of register offsets, field positions and reset values.
package event_status_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] SUMMARY_OFS    = 8'h18;
  localparam logic [7:0] STATUS_ONE_OFS = 8'h19;
  localparam logic [7:0] STATUS_TWO_OFS = 8'h1A;
  localparam logic [7:0] MASK_ONE_OFS   = 8'h40;
  localparam logic [7:0] MASK_TWO_OFS   = 8'h41;

  // ---------------------------------------------------------------
  // Field positions, first status register
  // ---------------------------------------------------------------
  localparam int CLK_PERIODIC_BIT = 7;
  localparam int CLK_SECOND_BIT   = 6;
  localparam int CLK_ALARM_BIT    = 5;
  localparam int BATT_HIGH_BIT    = 2;
  localparam int BATT_MID_BIT     = 1;
  localparam int BATT_LOW_BIT     = 0;

  // ---------------------------------------------------------------
  // Field positions, second status register and summary
  // ---------------------------------------------------------------
  localparam int SINK_ONE_BIT     = 13;
  localparam int SINK_TWO_BIT     = 12;
  localparam int USB_LIMIT_BIT    = 10;
  localparam int AUX_READY_BIT    = 8;
  localparam int AUX_COMP_LSB     = 4;
  localparam int AUX_COMP_N       = 4;
  localparam int AUX_GROUP_BIT    = 5;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [15:0] STATUS_RST = 16'h0000;
  localparam logic [15:0] MASK_RST   = 16'h0000;

endpackage

// ---- sim/event_source_model.sv ----
// Model of the event sources that drive the status latches.
`timescale 1ns/1ns
module event_source_model (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [13:0] fire,
  output logic      [13:0] level
);
  logic [13:0] firePrev;

  // Each requested event becomes a level held high for two cycles.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      firePrev <= '0;
      level    <= '0;
    end else begin
      firePrev <= fire;
      level    <= fire | firePrev;
    end
  end
endmodule

// ---- sim/tb.sv ----
// Self-checking testbench of the event status latches.
`timescale 1ns/1ns
module tb;
  import event_status_pkg::*;
  logic        clk      = 1'b0;
  logic        rst_n    = 1'b0;
  logic [7:0]  regAddr  = '0;
  logic [15:0] regWdata = '0;
  logic        regWrite = 1'b0;
  logic        regRead  = 1'b0;
  logic [13:0] fire     = '0;
  logic [13:0] level;
  logic [15:0] regRdata;
  logic [15:0] d;
  logic        irq;
  int          bad_count = 0;
  int          checked   = 0;
  int pos [14] = '{CLK_PERIODIC_BIT, CLK_SECOND_BIT, CLK_ALARM_BIT,
    BATT_HIGH_BIT, BATT_MID_BIT, BATT_LOW_BIT, SINK_ONE_BIT, SINK_TWO_BIT,
    USB_LIMIT_BIT, AUX_READY_BIT, AUX_COMP_LSB, AUX_COMP_LSB + 1,
    AUX_COMP_LSB + 2, AUX_COMP_LSB + 3};
  logic [7:0] ofs [5] = '{SUMMARY_OFS, STATUS_ONE_OFS, STATUS_TWO_OFS,
    MASK_ONE_OFS, MASK_TWO_OFS};

  always #50 clk = ~clk;

  event_source_model event_source_model_i (
    .clk(clk), .rst_n(rst_n), .fire(fire), .level(level));

  event_status_latches event_status_latches_i (
    .clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .clockPeriodicEvent(level[0]), .clockSecondTickEvent(level[1]),
    .clockAlarmEvent(level[2]), .batteryBelowHighEvent(level[3]),
    .batteryBelowMidEvent(level[4]), .batteryBelowLowEvent(level[5]),
    .sinkOneRegulationLost(level[6]), .sinkTwoRegulationLost(level[7]),
    .usbCurrentLimitEvent(level[8]), .auxConversionReadyEvent(level[9]),
    .auxComparatorEvent(level[13:10]), .irq(irq));

  // ---------------------------------------------------------------
  // Bus and check tasks
  // ---------------------------------------------------------------
  task automatic conclude();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic check(string what, logic [15:0] exp, logic [15:0] got);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(logic [7:0] a, logic [15:0] v);
    @(posedge clk);
    regWrite <= 1'b1;
    regAddr  <= a;
    regWdata <= v;
    @(posedge clk);
    regWrite <= 1'b0;
    @(negedge clk);
  endtask

  task automatic rd(logic [7:0] a, output logic [15:0] v);
    @(posedge clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRead <= 1'b0;
    @(negedge clk);
    v = regRdata;
  endtask

  task automatic pulse(int i);
    @(posedge clk);
    fire <= 14'h1 << i;
    @(posedge clk);
    fire <= '0;
    repeat (4) @(posedge clk);
    @(negedge clk);
  endtask

  // ---------------------------------------------------------------
  // Watchdog against a hang
  // ---------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    conclude();
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    foreach (ofs[k]) begin
      rd(ofs[k], d);
      check("reset value", 16'h0000, d);
    end
    for (int i = 0; i < 14; i++) begin
      pulse(i);
      rd(i < 6 ? STATUS_ONE_OFS : STATUS_TWO_OFS, d);
      check("event bit", 16'h0001 << pos[i], d);
      rd(i < 6 ? STATUS_ONE_OFS : STATUS_TWO_OFS, d);
      check("after read", 16'h0000, d);
    end
    rd(SUMMARY_OFS, d);
    check("summary", 16'h0001 << AUX_GROUP_BIT, d);
    rd(SUMMARY_OFS, d);
    check("summary read", 16'h0000, d);
    // Masked and unmasked interrupt with a second-register event.
    wr(MASK_TWO_OFS, 16'hFFFF);
    pulse(8);
    check("irq enabled", 16'h0001, {15'h0, irq});
    wr(MASK_TWO_OFS, 16'h0000);
    check("irq masked", 16'h0000, {15'h0, irq});
    wr(MASK_TWO_OFS, 16'h0001 << USB_LIMIT_BIT);
    check("irq unmasked", 16'h0001, {15'h0, irq});
    rd(MASK_TWO_OFS, d);
    check("mask two", 16'h0001 << USB_LIMIT_BIT, d);
    rd(STATUS_TWO_OFS, d);
    check("usb bit", 16'h0001 << USB_LIMIT_BIT, d);
    check("irq cleared", 16'h0000, {15'h0, irq});
    pulse(6);
    check("irq other mask", 16'h0000, {15'h0, irq});
    rd(STATUS_TWO_OFS, d);
    check("sink bit", 16'h0001 << SINK_ONE_BIT, d);
    // A level held across two reads is reported only once.
    @(posedge clk);
    fire <= 14'h1 << 8;
    repeat (3) @(posedge clk);
    rd(STATUS_TWO_OFS, d);
    check("usb held", 16'h0001 << USB_LIMIT_BIT, d);
    rd(STATUS_TWO_OFS, d);
    check("usb no retrigger", 16'h0000, d);
    check("irq held", 16'h0000, {15'h0, irq});
    @(posedge clk);
    fire <= '0;
    repeat (3) @(posedge clk);
    rd(STATUS_TWO_OFS, d);
    check("usb fall", 16'h0000, d);
    wr(MASK_ONE_OFS, 16'h0001 << CLK_ALARM_BIT);
    pulse(2);
    check("irq alarm", 16'h0001, {15'h0, irq});
    rd(STATUS_ONE_OFS, d);
    check("alarm bit", 16'h0001 << CLK_ALARM_BIT, d);
    check("irq alarm clear", 16'h0000, {15'h0, irq});
    // Writes to status and reads of unmapped places change nothing.
    wr(STATUS_ONE_OFS, 16'hFFFF);
    rd(STATUS_ONE_OFS, d);
    check("status write", 16'h0000, d);
    rd(8'h77, d);
    check("unmapped", 16'h0000, d);
    // A reset in mid-run clears flags, masks and the interrupt.
    wr(MASK_ONE_OFS, 16'hFFFF);
    pulse(5);
    check("irq battery", 16'h0001, {15'h0, irq});
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    check("irq reset", 16'h0000, {15'h0, irq});
    rd(MASK_ONE_OFS, d);
    check("mask reset", 16'h0000, d);
    rd(STATUS_ONE_OFS, d);
    check("status reset", 16'h0000, d);
    conclude();
  end
endmodule
